// [src/etc_counter.sv]
// elapsed time capture counter: free-running 40-bit count and trigger capture
// assumes the vco ticks, trigger pin and chip select are synchronous to CLK,
// and that the serial controller pulses one read strobe per byte read
//
// Functional notes
// - source select: 0 vco3, 1 vco2
// - vco3 source advances count every 8 ticks
// - vco2 source advances count every 20 ticks
// - trigger select: 1 pin, 0 chip select
// - counting and capture only while enabled
// - chip select falling edge captures live count
// - msb read blocks captures until lsb read
// - one multibyte read captures and re-arms
// - pin function 0x27 triggers; invert picks edge
// - pin capture blocks further pin captures until lsb
// - count up, wrap from all ones to zero
// - capture stores a 40-bit value
// - disabled counter held at zero
// - source select also picks validation vco
// - clear control held at 0 for counting
// - absolute measurement starts from enable transition

`timescale 1ns/1ps
`default_nettype none

module etc_counter
(
    // clock and reset
    input  wire logic                           CLK,
    input  wire logic                           ARST_N,

    // configuration bits
    input  wire etc_pkg::etc_config_type        CONFIG,

    // serial side
    input  wire logic                           SERIAL_CHIP_SELECT_N,
    input  wire etc_pkg::etc_read_type          READ_EVENT,

    // trigger pin and vco ticks
    input  wire logic                           TRIGGER_PIN,
    input  wire logic                           VCO3_TICK,
    input  wire logic                           VCO2_TICK,

    // results
    output logic [etc_pkg::COUNT_W-1:0]         CAPTURED_COUNT_FIELD,
    output logic [etc_pkg::COUNT_W-1:0]         LIVE_COUNT,
    output logic                                CAPTURE_ARMED,
    output logic                                CAPTURE_EVENT,
    output logic                                COUNTER_RUNNING,
    output logic                                VALIDATION_VCO_SELECT
);

    // rising edge seen between two samples
    function automatic logic rise(input logic prev, input logic cur);
        rise = cur & ~prev;
    endfunction : rise

    etc_pkg::etc_state_type state;
    etc_pkg::etc_state_type next_state;

    always_comb
    begin
        logic                                tick;
        logic [etc_pkg::PRESCALE_W-1:0]      divide;
        logic                                advance;
        logic                                hold_zero;
        logic                                enable_rise;
        logic                                pin_level;
        logic                                pin_is_trigger;
        logic                                pin_edge;
        logic                                cs_fall;
        logic                                trigger;
        logic                                do_capture;
        logic                                arm_set;
        logic                                arm_clear;

        tick = 1'b0;
        divide = etc_pkg::DIV_VCO3;
        advance = 1'b0;
        hold_zero = 1'b0;
        enable_rise = 1'b0;
        pin_level = 1'b0;
        pin_is_trigger = 1'b0;
        pin_edge = 1'b0;
        cs_fall = 1'b0;
        trigger = 1'b0;
        do_capture = 1'b0;
        arm_set = 1'b0;
        arm_clear = 1'b0;
        next_state = state;

        // edge history is always tracked so a late enable sees no stale edge
        next_state.vco3_prev = VCO3_TICK;
        next_state.vco2_prev = VCO2_TICK;
        next_state.chip_select_n_prev = SERIAL_CHIP_SELECT_N;
        next_state.enable_seen = CONFIG.elapsed_counter_enable;

        // the same select also steers missing-clock validation upstream
        next_state.validation_vco = CONFIG.vco_source_select;

        // counter clock: selected vco tick divided down
        if (CONFIG.vco_source_select == etc_pkg::SRC_VCO3)
        begin
            tick = rise(state.vco3_prev, VCO3_TICK);
            divide = etc_pkg::DIV_VCO3;
        end
        else
        begin
            tick = rise(state.vco2_prev, VCO2_TICK);
            divide = etc_pkg::DIV_VCO2;
        end

        // disabled or cleared counter sits at zero
        hold_zero = ~CONFIG.elapsed_counter_enable
                    | CONFIG.elapsed_counter_clear;
        enable_rise = rise(state.enable_seen, CONFIG.elapsed_counter_enable);

        if (hold_zero)
        begin
            // zero prescale too, so counting restarts cleanly from enable
            next_state.count = etc_pkg::COUNT_ZERO;
            next_state.prescale = etc_pkg::PRESCALE_ZERO;
        end
        else if (tick)
        begin
            if (state.prescale >= divide - etc_pkg::PRESCALE_ONE)
            begin
                next_state.prescale = etc_pkg::PRESCALE_ZERO;
                advance = 1'b1;
            end
            else
            begin
                next_state.prescale = state.prescale + etc_pkg::PRESCALE_ONE;
            end
        end

        // 40-bit add wraps from all ones to zero by itself
        if (advance)
        begin
            next_state.count = state.count + etc_pkg::COUNT_ONE;
        end
        next_state.running = ~hold_zero;

        // pin trigger: invert bit chooses the active edge
        pin_level = TRIGGER_PIN ^ CONFIG.pin_polarity_invert;
        next_state.pin_prev = pin_level;
        pin_is_trigger = (CONFIG.pin_function_select
                          == etc_pkg::FUNC_CAPTURE_TRIGGER);
        pin_edge = pin_is_trigger & rise(state.pin_prev, pin_level);
        cs_fall = rise(~state.chip_select_n_prev, ~SERIAL_CHIP_SELECT_N);

        if (CONFIG.capture_trigger_select == etc_pkg::TRIG_PIN)
        begin
            trigger = pin_edge;
        end
        else
        begin
            trigger = cs_fall;
        end

        // capture only while enabled and armed
        do_capture = trigger & CONFIG.elapsed_counter_enable
                     & state.armed;
        next_state.capture_pulse = do_capture;
        if (do_capture)
        begin
            // live count taken as is; nothing extra needed before the read
            next_state.captured = state.count;
        end

        // armed flag: pin capture or msb read disarms, lsb read re-arms
        arm_clear = (do_capture
                     & (CONFIG.capture_trigger_select == etc_pkg::TRIG_PIN))
                    | READ_EVENT.read_msb;
        arm_set = READ_EVENT.read_lsb | enable_rise;

        // set beats clear so an lsb read in the same cycle is never lost
        if (arm_set)
        begin
            next_state.armed = 1'b1;
        end
        else if (arm_clear)
        begin
            next_state.armed = 1'b0;
        end
    end

    always_ff @(posedge CLK or negedge ARST_N)
    begin
        if (!ARST_N)
        begin
            state.count <= etc_pkg::COUNT_ZERO;
            state.prescale <= etc_pkg::PRESCALE_ZERO;
            state.captured <= etc_pkg::COUNT_ZERO;
            state.armed <= 1'b1;
            state.capture_pulse <= 1'b0;
            state.enable_seen <= 1'b0;
            state.chip_select_n_prev <= 1'b1;
            state.pin_prev <= 1'b0;
            state.vco3_prev <= 1'b0;
            state.vco2_prev <= 1'b0;
            state.validation_vco <= etc_pkg::SRC_VCO3;
            state.running <= 1'b0;
        end
        else
        begin
            state <= next_state;
        end
    end

    // outputs straight from state flops
    assign CAPTURED_COUNT_FIELD = state.captured;
    assign LIVE_COUNT = state.count;
    assign CAPTURE_ARMED = state.armed;
    assign CAPTURE_EVENT = state.capture_pulse;
    assign COUNTER_RUNNING = state.running;
    assign VALIDATION_VCO_SELECT = state.validation_vco;

endmodule : etc_counter

`default_nettype wire

// [src/etc_pkg.sv]
// package for the elapsed time capture counter
// assumes one 125 MHz system clock; every other input but the asynchronous ARST_N is sampled on it
package etc_pkg;

    // counter geometry
    localparam int unsigned COUNT_W = 40;
    localparam int unsigned PRESCALE_W = 5;
    localparam int unsigned FUNC_W = 6;

    // source select codes for the counter clock
    localparam logic SRC_VCO3 = 1'b0;
    localparam logic SRC_VCO2 = 1'b1;

    // dividers applied to the selected vco tick
    localparam logic [PRESCALE_W-1:0] DIV_VCO3 = 5'h08;
    localparam logic [PRESCALE_W-1:0] DIV_VCO2 = 5'h14;

    // trigger select codes
    localparam logic TRIG_CHIP_SELECT = 1'b0;
    localparam logic TRIG_PIN = 1'b1;

    // pin function code that makes the pin a capture trigger
    localparam logic [FUNC_W-1:0] FUNC_CAPTURE_TRIGGER = 6'h27;

    // reset values and unit steps
    localparam logic [COUNT_W-1:0] COUNT_ZERO = 40'h00_0000_0000;
    localparam logic [COUNT_W-1:0] COUNT_ONE = 40'h00_0000_0001;
    localparam logic [PRESCALE_W-1:0] PRESCALE_ZERO = 5'h00;
    localparam logic [PRESCALE_W-1:0] PRESCALE_ONE = 5'h01;

    // configuration carried as one group
    typedef struct packed {
        logic                  vco_source_select;
        logic                  capture_trigger_select;
        logic                  elapsed_counter_enable;
        logic                  elapsed_counter_clear;
        logic [FUNC_W-1:0]     pin_function_select;
        logic                  pin_polarity_invert;
    } etc_config_type;

    // read events reported by the serial controller
    typedef struct packed {
        logic                  read_msb;
        logic                  read_lsb;
    } etc_read_type;

    // whole state of the counter block
    typedef struct packed {
        logic [COUNT_W-1:0]    count;
        logic [PRESCALE_W-1:0] prescale;
        logic [COUNT_W-1:0]    captured;
        logic                  armed;
        logic                  capture_pulse;
        logic                  enable_seen;
        logic                  chip_select_n_prev;
        logic                  pin_prev;
        logic                  vco3_prev;
        logic                  vco2_prev;
        logic                  validation_vco;
        logic                  running;
    } etc_state_type;

endpackage : etc_pkg

// [verif/etc_host_model.sv]
// host serial controller and trigger source facing the counter
// assumes its tasks are called just after a falling edge of CLK
`timescale 1ns/1ps
`default_nettype none
module etc_host_model
(
    // clock
    input  wire logic                CLK,
    // towards the counter
    output var logic                 SERIAL_CHIP_SELECT_N,
    output var etc_pkg::etc_read_type READ_EVENT,
    output var logic                 TRIGGER_PIN,
    output var logic                 VCO3_TICK,
    output var logic                 VCO2_TICK
);
    initial
    begin
        SERIAL_CHIP_SELECT_N = 1'b1;
        READ_EVENT = '0;
        TRIGGER_PIN = 1'b0;
        VCO3_TICK = 1'b0;
        VCO2_TICK = 1'b0;
    end
    // ticks run free: one rising tick every second cycle
    always @(negedge CLK)
    begin
        VCO3_TICK <= ~VCO3_TICK;
        VCO2_TICK <= ~VCO2_TICK;
    end
    // one frame: select, optional msb byte, optional lsb byte, release
    task frame(input logic msb, input logic lsb, input int gap);
        SERIAL_CHIP_SELECT_N = 1'b0;
        repeat (gap + 1) @(negedge CLK);
        READ_EVENT.read_msb = msb;
        @(negedge CLK);
        READ_EVENT.read_msb = 1'b0;
        READ_EVENT.read_lsb = lsb;
        @(negedge CLK);
        READ_EVENT.read_lsb = 1'b0;
        SERIAL_CHIP_SELECT_N = 1'b1;
        @(negedge CLK);
    endtask : frame
    task pin_to(input logic level, input int hold);
        TRIGGER_PIN = level;
        repeat (hold < 2 ? 2 : hold) @(negedge CLK);
    endtask : pin_to
endmodule : etc_host_model
`default_nettype wire

// [verif/etc_assertions.sv]
// checker for the elapsed time capture counter, bound to its top module
// assumes etc_pkg is compiled first
`timescale 1ns/1ps
`default_nettype none
module etc_assertions
(
    // clock and reset
    input wire logic                        CLK,
    input wire logic                        ARST_N,
    // watched ports
    input wire etc_pkg::etc_config_type     CONFIG,
    input wire logic                        SERIAL_CHIP_SELECT_N,
    input wire etc_pkg::etc_read_type       READ_EVENT,
    input wire logic                        TRIGGER_PIN,
    input wire logic [etc_pkg::COUNT_W-1:0] CAPTURED_COUNT_FIELD,
    input wire logic [etc_pkg::COUNT_W-1:0] LIVE_COUNT,
    input wire logic                        CAPTURE_ARMED,
    input wire logic                        CAPTURE_EVENT,
    input wire logic                        VALIDATION_VCO_SELECT
);
    logic en;
    logic go;
    logic pin_go;
    assign en = CONFIG.elapsed_counter_enable;
    assign go = en && CAPTURE_ARMED;
    assign pin_go = go && CONFIG.capture_trigger_select
        && CONFIG.pin_function_select == etc_pkg::FUNC_CAPTURE_TRIGGER;
    default clocking cb @(posedge CLK); endclocking
    default disable iff (!ARST_N);
    a_held_at_zero: assert property (!en || CONFIG.elapsed_counter_clear
        |=> LIVE_COUNT == etc_pkg::COUNT_ZERO) else $error("count not held at zero");
    a_count_steps_one: assert property ($changed(LIVE_COUNT)
        |-> LIVE_COUNT == $past(LIVE_COUNT) + etc_pkg::COUNT_ONE
        || LIVE_COUNT == etc_pkg::COUNT_ZERO) else $error("count step wrong");
    a_vco_select_copy: assert property (1'b1
        |=> VALIDATION_VCO_SELECT == $past(CONFIG.vco_source_select)) else $error("vco select");
    a_cs_capture_taken: assert property (go && !CONFIG.capture_trigger_select
        && $fell(SERIAL_CHIP_SELECT_N) |=> CAPTURED_COUNT_FIELD == $past(LIVE_COUNT)
        && CAPTURE_EVENT) else $error("chip select capture wrong");
    a_pin_capture_taken: assert property (pin_go
        && $rose(TRIGGER_PIN ^ CONFIG.pin_polarity_invert)
        && !READ_EVENT.read_lsb && !$rose(en)
        |=> CAPTURED_COUNT_FIELD == $past(LIVE_COUNT) && !CAPTURE_ARMED)
        else $error("pin capture wrong");
    a_disarmed_holds: assert property (!CAPTURE_ARMED && !$rose(en)
        |=> $stable(CAPTURED_COUNT_FIELD)) else $error("capture while disarmed");
    a_msb_disarms: assert property (READ_EVENT.read_msb && !READ_EVENT.read_lsb
        && !$rose(en) |=> !CAPTURE_ARMED) else $error("msb read left armed");
    a_lsb_rearms: assert property (READ_EVENT.read_lsb || $rose(en)
        |=> CAPTURE_ARMED) else $error("not rearmed");
    c_cs_capture: cover property (CAPTURE_EVENT && !CONFIG.capture_trigger_select);
    c_pin_capture: cover property (CAPTURE_EVENT && CONFIG.capture_trigger_select);
    c_rearm: cover property (READ_EVENT.read_lsb ##1 CAPTURE_ARMED);
endmodule : etc_assertions
bind etc_counter etc_assertions u_chk (.CLK, .ARST_N, .CONFIG, .SERIAL_CHIP_SELECT_N,
    .READ_EVENT, .TRIGGER_PIN, .CAPTURED_COUNT_FIELD, .LIVE_COUNT, .CAPTURE_ARMED,
    .CAPTURE_EVENT, .VALIDATION_VCO_SELECT);
`default_nettype wire

// [verif/tb.sv]
// self-checking bench for the elapsed time capture counter
// assumes package, counter, host model and checker are compiled first
`timescale 1ns/1ps
`default_nettype none
module tb;
    logic                        clk;
    logic                        arst_n;
    etc_pkg::etc_config_type     cfg;
    etc_pkg::etc_read_type       rd;
    logic                        cs_n, pin, vco3, vco2, armed, running, vsel;
    logic [etc_pkg::COUNT_W-1:0] cap, live, e, e0;
    int                          err_total = 0;
    int                          samples_checked = 0;
    etc_counter dut (.CLK(clk), .ARST_N(arst_n), .CONFIG(cfg), .SERIAL_CHIP_SELECT_N(cs_n),
        .READ_EVENT(rd), .TRIGGER_PIN(pin), .VCO3_TICK(vco3), .VCO2_TICK(vco2),
        .CAPTURED_COUNT_FIELD(cap), .LIVE_COUNT(live), .CAPTURE_ARMED(armed),
        .CAPTURE_EVENT(), .COUNTER_RUNNING(running), .VALIDATION_VCO_SELECT(vsel));
    etc_host_model host (.CLK(clk), .SERIAL_CHIP_SELECT_N(cs_n), .READ_EVENT(rd),
        .TRIGGER_PIN(pin), .VCO3_TICK(vco3), .VCO2_TICK(vco2));
    task check(input string name, input logic [39:0] exp, input logic [39:0] got);
        samples_checked++;
        if (got !== exp)
        begin
            err_total++;
            $display("mismatch %s expected %h seen %h", name, exp, got);
        end
    endtask : check
    task conclude;
        $display("checks %0d mismatches %0d", samples_checked, err_total);
        if (err_total == 0 && samples_checked > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask : conclude
    // count over a whole number of prescale periods, so phase does not matter
    task rate(input int span, input int steps);
        e = live + 40'(steps);
        repeat (span) @(negedge clk);
        check("live_count rate", e, live);
    endtask : rate
    task cs_cap(input logic msb, input logic lsb, input logic take, input string name);
        e0 = cap;
        e = live;
        host.frame(msb, lsb, 0);
        check(name, take ? e : e0, cap);
    endtask : cs_cap
    task pin_cap(input logic level, input logic take, input string name);
        e0 = cap;
        e = live;
        host.pin_to(level, 2);
        check(name, take ? e : e0, cap);
    endtask : pin_cap
    initial
    begin
        // starts high so time zero gives the host model no false falling edge
        clk = 1'b1;
        forever #4 clk = ~clk;
    end
    initial
    begin
        repeat (20000) @(posedge clk);
        err_total++;
        conclude();
    end
    initial
    begin
        arst_n = 1'b0;
        cfg = '0;
        repeat (5) @(negedge clk);
        arst_n = 1'b1;
        check("live_count", etc_pkg::COUNT_ZERO, live);
        check("capture_armed", 40'h00_0000_0001, armed);
        // trigger pin stays low for many cycles around this enable
        cfg.elapsed_counter_enable = 1'b1;
        cfg.pin_function_select = etc_pkg::FUNC_CAPTURE_TRIGGER;
        repeat (2) @(negedge clk);
        check("counter_running", 40'h00_0000_0001, running);
        rate(160, 10);
        cs_cap(1'b0, 1'b0, 1'b1, "cs capture");
        cs_cap(1'b1, 1'b0, 1'b1, "cs capture msb read");
        cs_cap(1'b0, 1'b0, 1'b0, "cs after msb read");
        cs_cap(1'b0, 1'b1, 1'b0, "cs lsb read");
        cs_cap(1'b1, 1'b1, 1'b1, "multibyte read");
        cs_cap(1'b0, 1'b0, 1'b1, "cs rearmed");
        cfg.capture_trigger_select = etc_pkg::TRIG_PIN;
        cs_cap(1'b0, 1'b1, 1'b0, "cs in pin mode");
        repeat (125) @(negedge clk);
        cfg.pin_function_select = 6'h00;
        pin_cap(1'b1, 1'b0, "pin other function");
        host.pin_to(1'b0, 2);
        cfg.pin_function_select = etc_pkg::FUNC_CAPTURE_TRIGGER;
        pin_cap(1'b1, 1'b1, "pin rise");
        host.pin_to(1'b0, 2);
        pin_cap(1'b1, 1'b0, "pin rise disarmed");
        cfg.pin_polarity_invert = 1'b1;
        cs_cap(1'b0, 1'b1, 1'b0, "lsb read rearm");
        repeat (125) @(negedge clk);
        pin_cap(1'b0, 1'b1, "pin fall inverted");
        // enable toggle restarts the count from zero
        cfg.elapsed_counter_enable = 1'b0;
        repeat (2) @(negedge clk);
        check("live_count disabled", etc_pkg::COUNT_ZERO, live);
        cfg.elapsed_counter_enable = 1'b1;
        cfg.elapsed_counter_clear = 1'b1;
        repeat (40) @(negedge clk);
        check("live_count cleared", etc_pkg::COUNT_ZERO, live);
        cfg.elapsed_counter_clear = 1'b0;
        cfg.vco_source_select = etc_pkg::SRC_VCO2;
        repeat (40) @(negedge clk);
        check("validation_vco", 40'h00_0000_0001, vsel);
        rate(400, 10);
        conclude();
    end
endmodule : tb
`default_nettype wire
